// ===== logic/rsp_pkg.sv
// Package: constants for the reset source and power-on-clear block
package rsp_pkg;
  localparam int  FLAG_W          = 8;
  localparam int  LVD_BIT         = 0;
  localparam int  WDT_BIT         = 1;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int  CLK_MHZ         = 40;
  localparam real PROC_MIN_MS     = 1.0;
  localparam real RISE_WINDOW_MS  = 3.7;
  localparam real SHORT_PROC_US   = 12.0;
  localparam int  PROC_MIN_CYC    = int'($ceil(PROC_MIN_MS * 1000.0 * CLK_MHZ));
  localparam int  RISE_WINDOW_CYC = int'($floor(RISE_WINDOW_MS * 1000.0 * CLK_MHZ));
  localparam int  SHORT_PROC_CYC  = int'($ceil(SHORT_PROC_US * CLK_MHZ));
  localparam int  CNT_W           = 18;
  localparam int  SYN_W           = 5;
  localparam int  SYN_EXT         = 0;
  localparam int  SYN_RISE        = 1;
  localparam int  SYN_FALL        = 2;
  localparam int  SYN_DET         = 3;
  localparam int  SYN_DSTART      = 4;
  localparam logic [4:0] SYN_RST  = 5'b0_0100;
  typedef enum logic [3:0] {
    S_HOLD  = 4'b0001,
    S_WAIT  = 4'b0010,
    S_DELAY = 4'b0100,
    S_RUN   = 4'b1000
  } rsp_state_t;
endpackage : rsp_pkg

// ===== logic/rsp_reset_sequencer.sv
// Reset source flags and power-on-clear sequencer
// Notes on behaviour
// R1: Register holds one watchdog flag and one voltage-monitor flag; 1 means that source reset.
// R2: External reset pin and power-on clear zero the whole register; a read zeroes it except a flag that a request sets in the same cycle.
// R3: Software reads the register only as a whole byte, never per bit.
// R4: Watchdog sets its flag; detector sets its flag; default-start reset clears both.
// R5: Watchdog or detector reset never zeroes the register, only sets its own flag.
// R6: Reset asserts at power-up and releases when supply passes the rise threshold.
// R7: Reset asserts whenever supply falls below the fall threshold.
// R8: With default start, reset holds until supply passes the detector threshold.
// R9: Fast rise under 3.7 ms: release about 1.0 ms after fall threshold.
// R10: Slow rise over 3.7 ms: release about 12 us after detector threshold.
// R11: Software configures the detector only after reset release.
// R12: Slow supply rise needs the reset pin held low externally.
// R13: Software should wait out supply fluctuation before initialising ports.
// R14: Voltage-monitor flag sits at bit 0.
// R15: A read returns old flags; the clear follows after the data is delivered.
// R16: Unused bits read zero; watchdog flag sits at bit 1.
`timescale 1ns/1ps
module rsp_reset_sequencer
  import rsp_pkg::*;
#(
  parameter int unsigned PROC_MIN    = PROC_MIN_CYC,
  parameter int unsigned RISE_WINDOW = RISE_WINDOW_CYC
) (
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic              CLOCK_ENABLE,
  input  wire logic              EXT_RESET_PIN_N,
  input  wire logic              SUPPLY_ABOVE_RISE,
  input  wire logic              SUPPLY_BELOW_FALL,
  input  wire logic              SUPPLY_ABOVE_DETECTOR,
  input  wire logic              DETECTOR_DEFAULT_START,
  input  wire logic              WATCHDOG_RESET_REQ,
  input  wire logic              DETECTOR_RESET_REQ,
  input  wire logic              FLAGS_READ,
  output logic [FLAG_W-1:0]      FLAGS_READ_DATA,
  output logic                   INTERNAL_RESET_N
);
  logic [SYN_W-1:0]  sync1;
  logic [SYN_W-1:0]  sync2;
  rsp_state_t        state;
  rsp_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [FLAG_W-1:0] reset_cause_flags;
  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] next_rd_data;
  logic              next_int_rst_n;
  logic              ext_ok;
  logic              rise_ok;
  logic              below_fall;
  logic              det_ok;
  logic              dstart;
  logic              clear_all;
  logic              dstart_drop;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction : sat_inc

  assign ext_ok      = sync2[SYN_EXT];
  assign rise_ok     = sync2[SYN_RISE];
  assign below_fall  = sync2[SYN_FALL];
  assign det_ok      = sync2[SYN_DET];
  assign dstart      = sync2[SYN_DSTART];
  assign clear_all   = !ext_ok || below_fall; // R2 R7
  assign dstart_drop = (state == S_RUN) && dstart && !det_ok;

  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt   = sat_inc(cnt);
    if (clear_all) begin
      next_state = S_HOLD; // R7
      next_cnt   = '0;
    end else begin
      case (state)
        S_HOLD: begin
          if (dstart) begin
            if (det_ok) begin // R8
              if (cnt < RISE_WINDOW[CNT_W-1:0]) begin
                next_state = S_WAIT; // R9
              end else begin
                next_state = S_DELAY; // R10
                next_cnt   = '0;
              end
            end
          end else if (rise_ok) begin
            next_state = S_RUN; // R6
          end
        end
        S_WAIT: begin
          if (!det_ok) begin
            next_state = S_HOLD;
          end else if (cnt >= PROC_MIN[CNT_W-1:0]) begin
            next_state = S_RUN; // R9
          end
        end
        S_DELAY: begin
          if (cnt >= CNT_W'(SHORT_PROC_CYC - 1)) begin
            next_state = S_RUN; // R10
          end
        end
        S_RUN: begin
          if (dstart_drop) begin
            next_state = S_HOLD;
            next_cnt   = '0;
          end else if (WATCHDOG_RESET_REQ || DETECTOR_RESET_REQ) begin
            next_state = S_DELAY;
            next_cnt   = '0;
          end
        end
        default: begin
          next_state = S_HOLD;
          next_cnt   = '0;
        end
      endcase
    end
    next_int_rst_n = (next_state == S_RUN);
  end

  // Reset cause flags and read port
  always_comb begin
    next_flags   = reset_cause_flags;
    next_rd_data = FLAGS_READ_DATA;
    if (FLAGS_READ) begin
      next_rd_data = reset_cause_flags; // R15 R3
      next_flags   = FLAGS_RST; // R2
    end
    if (WATCHDOG_RESET_REQ) begin
      next_flags[WDT_BIT] = 1'b1; // R4 R5 R16
    end
    if (DETECTOR_RESET_REQ) begin
      next_flags[LVD_BIT] = 1'b1; // R4 R5 R14
    end
    if (dstart_drop) begin
      next_flags = FLAGS_RST; // R4
    end
    if (clear_all) begin
      next_flags = FLAGS_RST; // R2
    end
    next_flags[FLAG_W-1:WDT_BIT+1] = '0; // R16 R1
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1             <= SYN_RST;
      sync2             <= SYN_RST;
      state             <= S_HOLD; // R6
      cnt               <= '0;
      reset_cause_flags <= FLAGS_RST;
      FLAGS_READ_DATA   <= FLAGS_RST;
      INTERNAL_RESET_N  <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      sync1             <= {DETECTOR_DEFAULT_START, SUPPLY_ABOVE_DETECTOR,
                            SUPPLY_BELOW_FALL, SUPPLY_ABOVE_RISE, EXT_RESET_PIN_N};
      sync2             <= sync1;
      state             <= next_state;
      cnt               <= next_cnt;
      reset_cause_flags <= next_flags;
      FLAGS_READ_DATA   <= next_rd_data;
      INTERNAL_RESET_N  <= next_int_rst_n;
    end
  end

  // Checks
  property p_upper_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
      FLAGS_READ_DATA[FLAG_W-1:WDT_BIT+1] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused flag bits set"); // R16

  property p_read_clears;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && FLAGS_READ && !WATCHDOG_RESET_REQ && !DETECTOR_RESET_REQ
      |=> reset_cause_flags == FLAGS_RST;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // R2

  property p_read_old;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && FLAGS_READ |=> FLAGS_READ_DATA == $past(reset_cause_flags);
  endproperty
  a_read_old: assert property (p_read_old) else $error("read data not old flags"); // R15

  property p_wdt_set;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && WATCHDOG_RESET_REQ && !clear_all && !dstart_drop
      |=> reset_cause_flags[WDT_BIT] && !INTERNAL_RESET_N;
  endproperty
  a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set"); // R4

  property p_lvd_hold_wdt;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && DETECTOR_RESET_REQ && !WATCHDOG_RESET_REQ && !FLAGS_READ
      && !clear_all && !dstart_drop
      |=> reset_cause_flags == ($past(reset_cause_flags) | 8'h01);
  endproperty
  a_lvd_hold_wdt: assert property (p_lvd_hold_wdt) else $error("detector reset lost flag"); // R5

  property p_fall_reset;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && below_fall |=> !INTERNAL_RESET_N && state == S_HOLD
      && reset_cause_flags == FLAGS_RST;
  endproperty
  a_fall_reset: assert property (p_fall_reset) else $error("fall did not reset"); // R7

  property p_rise_release;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && state == S_HOLD && !clear_all && !dstart && rise_ok
      |=> INTERNAL_RESET_N;
  endproperty
  a_rise_release: assert property (p_rise_release) else $error("no release at rise"); // R6

  property p_dstart_hold;
    @(posedge CLOCK) disable iff (!RESET_N)
      state == S_HOLD && dstart && !det_ok |=> !INTERNAL_RESET_N;
  endproperty
  a_dstart_hold: assert property (p_dstart_hold) else $error("released below detector"); // R8

  property p_short_delay;
    @(posedge CLOCK) disable iff (!RESET_N)
      CLOCK_ENABLE && state == S_DELAY && !clear_all
      && cnt == CNT_W'(SHORT_PROC_CYC - 1) |=> INTERNAL_RESET_N;
  endproperty
  a_short_delay: assert property (p_short_delay) else $error("short delay wrong"); // R10

  property p_wait_min;
    @(posedge CLOCK) disable iff (!RESET_N)
      state == S_WAIT && cnt < PROC_MIN[CNT_W-1:0] |=> !INTERNAL_RESET_N;
  endproperty
  a_wait_min: assert property (p_wait_min) else $error("released before minimum"); // R9

  c_wdt_reset: cover property (@(posedge CLOCK) disable iff (!RESET_N)
    state == S_RUN ##1 state == S_DELAY ##[1:600] state == S_RUN);
  c_fast_rise: cover property (@(posedge CLOCK) disable iff (!RESET_N)
    state == S_WAIT ##1 state == S_RUN);
  c_read: cover property (@(posedge CLOCK) disable iff (!RESET_N)
    FLAGS_READ && reset_cause_flags != FLAGS_RST);
endmodule : rsp_reset_sequencer

// ===== testbench/rsp_testbench.sv
// Self-checking bench for the reset source and power-on-clear sequencer
`timescale 1ns/1ps
module testbench;
  import rsp_pkg::*;
  logic             CLOCK, RESET_N, CLOCK_ENABLE, EXT_RESET_PIN_N, SUPPLY_ABOVE_RISE;
  logic             SUPPLY_BELOW_FALL, SUPPLY_ABOVE_DETECTOR, DETECTOR_DEFAULT_START;
  logic             WATCHDOG_RESET_REQ, DETECTOR_RESET_REQ, FLAGS_READ, INTERNAL_RESET_N;
  logic [7:0]       FLAGS_READ_DATA;
  int               n_mismatch, total_checks, n;
  // Watchdog request, detector request, expected flag byte
  logic [9:0]       rows [5] = '{10'h000, 10'h202, 10'h101, 10'h303, 10'h000};

  rsp_reset_sequencer #(.PROC_MIN(50), .RISE_WINDOW(200)) rsp_reset_sequencer_inst (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CLOCK_ENABLE(CLOCK_ENABLE),
    .EXT_RESET_PIN_N(EXT_RESET_PIN_N), .SUPPLY_ABOVE_RISE(SUPPLY_ABOVE_RISE),
    .SUPPLY_BELOW_FALL(SUPPLY_BELOW_FALL), .SUPPLY_ABOVE_DETECTOR(SUPPLY_ABOVE_DETECTOR),
    .DETECTOR_DEFAULT_START(DETECTOR_DEFAULT_START), .WATCHDOG_RESET_REQ(WATCHDOG_RESET_REQ),
    .DETECTOR_RESET_REQ(DETECTOR_RESET_REQ), .FLAGS_READ(FLAGS_READ),
    .FLAGS_READ_DATA(FLAGS_READ_DATA), .INTERNAL_RESET_N(INTERNAL_RESET_N));

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk8(input logic [7:0] exp);
    total_checks++;
    if (FLAGS_READ_DATA !== exp) begin
      n_mismatch++;
      $display("BAD %0t flags got %h exp %h", $time, FLAGS_READ_DATA, exp);
    end
  endtask : chk8

  task chk1(input logic exp);
    total_checks++;
    if (INTERNAL_RESET_N !== exp) begin
      n_mismatch++;
      $display("BAD %0t reset got %h exp %h", $time, INTERNAL_RESET_N, exp);
    end
  endtask : chk1

  task chk_rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("BAD %0t cycles got %h exp %h to %h", $time, v, lo, hi);
    end
  endtask : chk_rng

  task cyc(input int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask : cyc

  // Counts edges until internal reset releases, bounded
  task wait_run(output int c);
    c = 0;
    while (INTERNAL_RESET_N !== 1'b1) begin
      cyc(1);
      c++;
      if (c > 2000) begin
        n_mismatch++;
        finish_test;
      end
    end
  endtask : wait_run

  task rd(input logic [7:0] exp);
    @(posedge CLOCK) FLAGS_READ <= 1'b1;
    @(posedge CLOCK) FLAGS_READ <= 1'b0;
    #1 chk8(exp);
  endtask : rd

  // One-cycle watchdog (w=1) or detector (w=0) request
  task req(input logic w);
    @(posedge CLOCK);
    WATCHDOG_RESET_REQ <= w;
    DETECTOR_RESET_REQ <= !w;
    @(posedge CLOCK);
    WATCHDOG_RESET_REQ <= 1'b0;
    DETECTOR_RESET_REQ <= 1'b0;
    #1 chk1(1'b0);
    wait_run(n);
    chk_rng(n, 479, 481);
  endtask : req

  task por(input int k);
    @(posedge CLOCK) RESET_N <= 1'b0;
    cyc(k - 1);
    chk1(1'b0);
    chk8(8'h00);
    @(posedge CLOCK) RESET_N <= 1'b1;
    #1;
  endtask : por

  initial begin
    {RESET_N, WATCHDOG_RESET_REQ, DETECTOR_RESET_REQ, FLAGS_READ} = 4'h0;
    {SUPPLY_BELOW_FALL, DETECTOR_DEFAULT_START} = 2'b00;
    {CLOCK_ENABLE, EXT_RESET_PIN_N, SUPPLY_ABOVE_RISE, SUPPLY_ABOVE_DETECTOR} = 4'hf;
    por(6);
    wait_run(n);
    for (int i = 0; i < 5; i++) begin
      if (rows[i][9]) req(1'b1);
      if (rows[i][8]) req(1'b0);
      rd(rows[i][7:0]);
    end
    req(1'b1);
    @(posedge CLOCK) EXT_RESET_PIN_N <= 1'b0;
    cyc(4);
    chk1(1'b0);
    @(posedge CLOCK) EXT_RESET_PIN_N <= 1'b1;
    wait_run(n);
    rd(8'h00);
    req(1'b0);
    @(posedge CLOCK) SUPPLY_BELOW_FALL <= 1'b1;
    cyc(4);
    chk1(1'b0);
    @(posedge CLOCK) SUPPLY_BELOW_FALL <= 1'b0;
    wait_run(n);
    rd(8'h00);
    // Read strobe while frozen must not clear
    req(1'b1);
    @(posedge CLOCK);
    CLOCK_ENABLE <= 1'b0;
    FLAGS_READ <= 1'b1;
    @(posedge CLOCK);
    CLOCK_ENABLE <= 1'b1;
    FLAGS_READ <= 1'b0;
    rd(8'h02);
    // Read and detector request together: old byte out, set beats clear
    req(1'b1);
    @(posedge CLOCK);
    FLAGS_READ         <= 1'b1;
    DETECTOR_RESET_REQ <= 1'b1;
    @(posedge CLOCK);
    FLAGS_READ         <= 1'b0;
    DETECTOR_RESET_REQ <= 1'b0;
    #1 chk8(8'h02);
    wait_run(n);
    rd(8'h01);
    req(1'b1);
    // Slow rise: pin held low until the supply is up
    @(posedge CLOCK);
    SUPPLY_ABOVE_RISE <= 1'b0;
    EXT_RESET_PIN_N   <= 1'b0;
    por(3);
    cyc(20);
    chk1(1'b0);
    @(posedge CLOCK) SUPPLY_ABOVE_RISE <= 1'b1;
    cyc(10);
    chk1(1'b0);
    @(posedge CLOCK) EXT_RESET_PIN_N <= 1'b1;
    wait_run(n);
    cyc(8);
    rd(8'h00);
    @(posedge CLOCK);
    DETECTOR_DEFAULT_START <= 1'b1;
    SUPPLY_ABOVE_DETECTOR <= 1'b0;
    por(3);
    @(posedge CLOCK) SUPPLY_ABOVE_DETECTOR <= 1'b1;
    wait_run(n);
    chk_rng(n, 47, 56);
    @(posedge CLOCK) SUPPLY_ABOVE_DETECTOR <= 1'b0;
    por(3);
    cyc(250);
    chk1(1'b0);
    @(posedge CLOCK) SUPPLY_ABOVE_DETECTOR <= 1'b1;
    wait_run(n);
    chk_rng(n, 480, 486);
    req(1'b1);
    @(posedge CLOCK) SUPPLY_ABOVE_DETECTOR <= 1'b0;
    cyc(4);
    chk1(1'b0);
    @(posedge CLOCK) SUPPLY_ABOVE_DETECTOR <= 1'b1;
    wait_run(n);
    rd(8'h00);
    finish_test;
  end
endmodule : testbench
